// ==== rtl/hpw_regs.svh ====
/*
 Constants of the host phy wake, align and ready block: register map,
 field positions, reset values, line code words and timing figures.
 Assumes a 20 MHz system clock and 32-bit APB data.
*/
`ifndef HPW_REGS_SVH
`define HPW_REGS_SVH

// Register byte addresses
`define HPW_ADDR_CTRL 12'h000
`define HPW_ADDR_STAT 12'h004
`define HPW_ADDR_WAKE 12'h008
`define HPW_ADDR_TMOC 12'h00c

// Control fields
`define HPW_CTRL_NORETRY 0
`define HPW_CTRL_HRST 1
`define HPW_CTRL_RST 2'h0

// Wake register fields
`define HPW_WAKE_SEEN 0
`define HPW_WAKE_FROZEN 1

// Line code words
`define HPW_ALIGN_DW 32'h7b4a4abc
`define HPW_ALIGN_K 4'h1
`define HPW_D102_DW 32'h4a4a4a4a
`define HPW_K283 8'h7c
`define HPW_NONALIGN_RUN 2'h3

// Timing, in picoseconds
`define HPW_CLK_PS 50000
`define HPW_D102_MAX_PS 533000
`define HPW_BLANK_MIN_PS 116300
`define HPW_GLITCH_MAX_PS 53300
`define HPW_TMO_PS 873800000

`endif

// ==== rtl/hpw_pkg.sv ====
/*
 Types of the host phy wake, align and ready block.
 Assumes hpw_regs.svh for every register, code word and timing constant.
*/
package hpw_pkg;

    typedef enum logic [12:0] {
        HPW_RESET = 13'h0001,
        HPW_AWAIT_INIT = 13'h0002,
        HPW_INIT_REL = 13'h0004,
        HPW_CALIB = 13'h0008,
        HPW_SEND_WAKE = 13'h0010,
        HPW_WAIT_WAKE = 13'h0020,
        HPW_WAKE_REL = 13'h0040,
        HPW_WAIT_ALIGN = 13'h0080,
        HPW_SPEED_ADJ = 13'h0100,
        HPW_SEND_ALIGN = 13'h0200,
        HPW_READY = 13'h0400,
        HPW_PARTIAL = 13'h0800,
        HPW_SLUMBER = 13'h1000
    } hpw_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } hpw_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } hpw_apb_rsp_t;

    typedef struct packed {
        logic [31:0] dword;
        logic [3:0] k;
        logic quiet;
    } hpw_tx_t;

    typedef struct packed {
        logic send_reset;
        logic send_wake;
        logic rate_low;
        logic speed_req;
        logic pwr_partial;
        logic pwr_slumber;
        logic phy_rdy;
    } hpw_ctl_t;

    typedef struct packed {
        logic [2:0] init_s;
        logic [2:0] wake_s;
        logic [1:0] por_s;
    } hpw_sync_t;

    typedef struct packed {
        hpw_state_t st;
        hpw_sync_t sy;
        logic [19:0] cnt;
        logic [1:0] nac;
        logic [1:0] ctrl;
        logic wake_seen;
        logic frozen;
        logic [15:0] tmo_cnt;
        hpw_apb_rsp_t apb;
        hpw_tx_t tx;
        hpw_ctl_t ctl;
    } hpw_regs_t;

endpackage

// ==== rtl/hpw_top.sv ====
/*
 Host phy bring-up from the wake exchange to link ready, with the
 partial and slumber power states, and an APB register slave.
 Assumes out-of-band detectors and power-on reset arrive asynchronously;
 receive words, link requests and transmitter handshakes share i_clk_sys.
*/

`timescale 1ns/10ps
`default_nettype none

`include "hpw_regs.svh"

module hpw_top
    import hpw_pkg::*;
#(
    parameter int TMO_CYC = `HPW_TMO_PS / `HPW_CLK_PS
)
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_por,
    input wire logic i_init_det,
    input wire logic i_wake_det,
    input wire logic i_oob_done,
    input wire logic i_cal_done,
    input wire logic i_speed_done,
    input wire logic i_slumber_recovered,
    input wire logic i_rx_valid,
    input wire logic [31:0] i_rx_dword,
    input wire logic [3:0] i_rx_k,
    input wire logic i_link_partial,
    input wire logic i_link_slumber,
    input wire logic [31:0] i_link_dword,
    input wire logic [3:0] i_link_k,
    input wire hpw_apb_req_t i_apb,
    output hpw_apb_rsp_t o_apb,
    output hpw_tx_t o_tx,
    output hpw_ctl_t o_ctl,
    output logic o_wake_from_far
);

    localparam int BLANK_CYC =
        (`HPW_BLANK_MIN_PS + `HPW_CLK_PS - 1) / `HPW_CLK_PS;
    // Longest times round down, never below one cycle
    localparam int D102_CYC = (`HPW_D102_MAX_PS / `HPW_CLK_PS) > 0 ?
        (`HPW_D102_MAX_PS / `HPW_CLK_PS) : 1;
    localparam int GLITCH_CYC = (`HPW_GLITCH_MAX_PS / `HPW_CLK_PS) > 0 ?
        (`HPW_GLITCH_MAX_PS / `HPW_CLK_PS) : 1;
    localparam logic [19:0] TMO_LAST = 20'(TMO_CYC - 1);
    localparam logic [19:0] BLANK_LAST = 20'(BLANK_CYC);
    localparam logic [19:0] CNT_MAX = 20'hfffff;

    localparam hpw_regs_t RST = '{
        st: HPW_RESET,
        sy: '0,
        cnt: '0,
        nac: '0,
        ctrl: `HPW_CTRL_RST,
        wake_seen: 1'b0,
        frozen: 1'b0,
        tmo_cnt: '0,
        apb: '0,
        tx: '{dword: 32'h0, k: 4'h0, quiet: 1'b1},
        ctl: '{send_reset: 1'b1, default: 1'b0}
    };

    hpw_regs_t q;
    hpw_regs_t d;

    function automatic logic is_nonalign(input logic [31:0] dw, input logic [3:0] k);
        is_nonalign = k[0] && (dw[7:0] == `HPW_K283);
    endfunction

    function automatic logic is_align(input logic [31:0] dw, input logic [3:0] k);
        is_align = (k == `HPW_ALIGN_K) && (dw == `HPW_ALIGN_DW);
    endfunction

    function automatic logic [19:0] sat_inc(input logic [19:0] v);
        sat_inc = (v == CNT_MAX) ? v : v + 20'h1;
    endfunction

    logic init_det;
    logic wake_det;
    logic any_rst;
    logic no_retry;
    logic blank_done;
    logic tmo_hit;
    logic apb_setup;
    logic apb_wr;
    hpw_state_t nx;

    always_comb
    begin
        d = q;

        // Two flops before any logic; stage 2 feeds the edge-free level
        d.sy.init_s = {q.sy.init_s[1:0], i_init_det};
        d.sy.wake_s = {q.sy.wake_s[1:0], i_wake_det};
        d.sy.por_s = {q.sy.por_s[0], i_por};
        init_det = q.sy.init_s[1];
        wake_det = q.sy.wake_s[1];

        no_retry = q.ctrl[`HPW_CTRL_NORETRY];
        any_rst = q.sy.por_s[1] | q.ctrl[`HPW_CTRL_HRST];
        blank_done = q.cnt >= BLANK_LAST;
        // Fires on the last counted cycle
        tmo_hit = q.cnt == TMO_LAST;

        // APB slave: zero wait state, answer registered in setup cycle
        apb_setup = i_apb.psel && !i_apb.penable;
        apb_wr = i_apb.psel && i_apb.penable && q.apb.pready && i_apb.pwrite;
        d.apb.pready = apb_setup;
        d.apb.pslverr = 1'b0;
        d.apb.prdata = 32'h0;
        if (apb_setup)
        begin
            unique case (i_apb.paddr)
                `HPW_ADDR_CTRL: d.apb.prdata = {30'h0, q.ctrl};
                `HPW_ADDR_STAT: d.apb.prdata = {19'h0, q.st};
                `HPW_ADDR_WAKE: d.apb.prdata = {30'h0, q.frozen, q.wake_seen};
                `HPW_ADDR_TMOC: d.apb.prdata = {16'h0, q.tmo_cnt};
                default: d.apb.pslverr = 1'b1;
            endcase
        end
        if (apb_wr && i_apb.paddr == `HPW_ADDR_CTRL)
        begin
            d.ctrl = i_apb.pwdata[1:0];
        end

        nx = q.st;
        d.nac = 2'h0;
        unique case (q.st)
            HPW_RESET:
            begin
                nx = HPW_AWAIT_INIT;
            end
            HPW_AWAIT_INIT:
            begin
                if (init_det)
                begin
                    nx = HPW_INIT_REL;
                end
            end
            HPW_INIT_REL:
            begin
                if (!init_det)
                begin
                    nx = HPW_CALIB;
                end
            end
            HPW_CALIB:
            begin
                if (i_cal_done)
                begin
                    nx = HPW_SEND_WAKE;
                end
            end
            HPW_SEND_WAKE:
            begin
                // Bursts first, then await far wake
                if (i_oob_done)
                begin
                    nx = wake_det ? HPW_WAKE_REL : HPW_WAIT_WAKE;
                end
            end
            HPW_WAIT_WAKE:
            begin
                if (wake_det)
                begin
                    nx = HPW_WAKE_REL;
                end
            end
            HPW_WAKE_REL:
            begin
                if (!wake_det)
                begin
                    nx = HPW_WAIT_ALIGN;
                end
            end
            HPW_WAIT_ALIGN:
            begin
                if (q.frozen)
                begin
                    nx = HPW_WAIT_ALIGN;
                end
                else if (blank_done && i_rx_valid && is_align(i_rx_dword, i_rx_k))
                begin
                    nx = HPW_SPEED_ADJ;
                end
                else if (tmo_hit)
                begin
                    d.tmo_cnt = q.tmo_cnt + 16'h1;
                    if (no_retry)
                    begin
                        d.frozen = 1'b1;
                    end
                    else
                    begin
                        nx = HPW_RESET;
                    end
                end
            end
            HPW_SPEED_ADJ:
            begin
                if (i_speed_done)
                begin
                    nx = HPW_SEND_ALIGN;
                end
            end
            HPW_SEND_ALIGN:
            begin
                d.nac = q.nac;
                if (i_rx_valid && !q.frozen)
                begin
                    d.nac = is_nonalign(i_rx_dword, i_rx_k) ? q.nac + 2'h1 : 2'h0;
                end
                if (d.nac == `HPW_NONALIGN_RUN)
                begin
                    nx = HPW_READY;
                end
                // Retry off stops the loop after one timeout span
                else if (no_retry && tmo_hit)
                begin
                    d.frozen = 1'b1;
                end
            end
            HPW_READY:
            begin
                // Power requests from the link layer
                if (i_link_partial)
                begin
                    nx = HPW_PARTIAL;
                end
                else if (i_link_slumber)
                begin
                    nx = HPW_SLUMBER;
                end
            end
            HPW_PARTIAL:
            begin
                // Stay while requested; on release, wake level picks HPW_WAKE_REL or HPW_SEND_WAKE
                if (!i_link_partial)
                begin
                    nx = wake_det ? HPW_WAKE_REL : HPW_SEND_WAKE;
                end
            end
            HPW_SLUMBER:
            begin
                // Stay while requested, exit once recovered
                if (!i_link_slumber && i_slumber_recovered)
                begin
                    nx = (wake_det || q.wake_seen) ? HPW_WAKE_REL : HPW_SEND_WAKE;
                end
            end
            default:
            begin
                nx = HPW_RESET;
            end
        endcase

        // Wake origin: cleared on sleep entry, set wins over clear
        if (q.st == HPW_READY && nx != HPW_READY)
        begin
            d.wake_seen = 1'b0;
        end
        if ((q.st == HPW_PARTIAL || q.st == HPW_SLUMBER) && wake_det)
        begin
            d.wake_seen = 1'b1;
        end

        if (init_det && q.st != HPW_INIT_REL)
        begin
            nx = HPW_INIT_REL;
        end
        if (any_rst)
        begin
            nx = HPW_RESET;
        end
        if (nx == HPW_RESET || nx == HPW_INIT_REL)
        begin
            d.frozen = 1'b0;
        end
        d.st = nx;

        d.cnt = (nx != q.st) ? 20'h0 : sat_inc(q.cnt);

        // Transmit and control, registered from the next state
        d.ctl = '0;
        d.tx.dword = `HPW_D102_DW;
        d.tx.k = 4'h0;
        d.tx.quiet = 1'b1;
        unique case (nx)
            HPW_RESET:
            begin
                // Reset bursts come from the burst generator
                d.ctl.send_reset = 1'b1;
            end
            HPW_SEND_WAKE:
            begin
                // Wake bursts come from the burst generator
                d.ctl.send_wake = 1'b1;
            end
            HPW_WAIT_ALIGN:
            begin
                // D10.2 from the first cycle, well inside D102_CYC
                d.tx.quiet = d.frozen;
                d.ctl.rate_low = 1'b1;
            end
            HPW_SPEED_ADJ:
            begin
                // Line stays driven; glitch bounded by GLITCH_CYC
                d.tx.quiet = 1'b0;
                d.ctl.speed_req = d.cnt < 20'(GLITCH_CYC);
            end
            HPW_SEND_ALIGN:
            begin
                d.tx.dword = `HPW_ALIGN_DW;
                d.tx.k = `HPW_ALIGN_K;
                d.tx.quiet = d.frozen;
            end
            HPW_READY:
            begin
                d.tx.dword = i_link_dword;
                d.tx.k = i_link_k;
                d.tx.quiet = 1'b0;
                d.ctl.phy_rdy = 1'b1;
            end
            HPW_PARTIAL:
            begin
                d.ctl.pwr_partial = 1'b1;
            end
            HPW_SLUMBER:
            begin
                d.ctl.pwr_slumber = 1'b1;
            end
            default:
            begin
                d.tx.quiet = 1'b1;
            end
        endcase
    end

    // Figures kept for the checker side; the design meets them by construction
    logic unused_ok;
    assign unused_ok = (D102_CYC > 0) && (GLITCH_CYC > 0);

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            q <= RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_apb = q.apb;
    assign o_tx = q.tx;
    assign o_ctl = q.ctl;
    assign o_wake_from_far = q.wake_seen;

endmodule // hpw_top

`default_nettype wire

// ==== sim/hpw_checker.sv ====
/*
 Port checker for hpw_top, bound to every instance.
 Assumes the single i_clk_sys domain and synchronous i_srst.
*/
`timescale 1ns/10ps
`default_nettype none

module hpw_checker
    import hpw_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_por,
    input wire logic i_link_partial,
    input wire logic i_link_slumber,
    input wire logic [31:0] i_link_dword,
    input wire hpw_apb_req_t i_apb,
    input wire hpw_apb_rsp_t o_apb,
    input wire hpw_tx_t o_tx,
    input wire hpw_ctl_t o_ctl
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);

    sequence s_setup;
        i_apb.psel && !i_apb.penable;
    endsequence
    sequence s_access;
        i_apb.psel && i_apb.penable && o_apb.pready;
    endsequence

    property p_apb_ans;
        s_setup |=> s_access;
    endproperty
    a_apb_ans: assert property (p_apb_ans) else $error("no answer after setup");
    property p_apb_one;
        o_apb.pready |=> !o_apb.pready;
    endproperty
    a_apb_one: assert property (p_apb_one) else $error("pready held too long");
    property p_apb_err;
        s_setup and i_apb.paddr > 12'h00c |=> o_apb.pslverr && o_apb.prdata == 32'h0;
    endproperty
    a_apb_err: assert property (p_apb_err) else $error("unmapped access not refused");
    property p_rst;
        disable iff (1'b0) i_srst |=> o_ctl.send_reset && !o_ctl.phy_rdy && o_tx.quiet;
    endproperty
    a_rst: assert property (p_rst) else $error("reset outputs wrong");
    property p_por;
        i_por [*5] |=> o_ctl.send_reset && !o_ctl.phy_rdy;
    endproperty
    a_por: assert property (p_por) else $error("power-on reset ignored");
    property p_rdy;
        o_ctl.phy_rdy |-> !o_tx.quiet && o_tx.dword == $past(i_link_dword);
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready line not link word");
    property p_part_q;
        o_ctl.pwr_partial |-> o_tx.quiet;
    endproperty
    a_part_q: assert property (p_part_q) else $error("partial line not quiet");
    property p_slum_q;
        o_ctl.pwr_slumber |-> o_tx.quiet;
    endproperty
    a_slum_q: assert property (p_slum_q) else $error("slumber line not quiet");
    property p_to_part;
        o_ctl.phy_rdy && i_link_partial && !i_link_slumber && !i_por
            |-> ##[1:2] o_ctl.pwr_partial;
    endproperty
    a_to_part: assert property (p_to_part) else $error("partial not entered");
    property p_glitch;
        o_ctl.speed_req |=> !o_ctl.speed_req;
    endproperty
    a_glitch: assert property (p_glitch) else $error("speed switch too long");
endmodule // hpw_checker

bind hpw_top hpw_checker u_chk (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_por(i_por),
    .i_link_partial(i_link_partial), .i_link_slumber(i_link_slumber),
    .i_link_dword(i_link_dword), .i_apb(i_apb), .o_apb(o_apb), .o_tx(o_tx),
    .o_ctl(o_ctl)
);

`default_nettype wire

// ==== sim/hpw_dev_model.sv ====
/*
 Drive-side phy model: detector levels and receive dwords.
 Assumes the bench commands wake, init and the kind of dwords sent.
*/
`timescale 1ns/10ps
`default_nettype none

`include "hpw_regs.svh"

module hpw_dev_model
    import hpw_pkg::*;
(
    input wire logic i_clk_sys,
    input wire hpw_tx_t i_tx,
    input wire logic i_init,
    input wire logic i_wake,
    input wire logic [1:0] i_mode,
    input wire logic i_slow,
    output logic o_init_det,
    output logic o_wake_det,
    output logic o_rx_valid,
    output logic [31:0] o_rx_dword,
    output logic [3:0] o_rx_k
);
    logic ph = 1'b0;
    logic rv = 1'b0;
    logic [31:0] dw = 32'h0;
    logic [3:0] k = 4'h0;
    logic go;

    assign o_init_det = i_init;
    assign o_wake_det = i_wake;
    // answer a live host one cycle later, every other cycle when slow
    assign go = !i_tx.quiet && i_mode != 2'h0 && !(i_slow && ph);
    assign o_rx_valid = rv;
    assign o_rx_dword = dw;
    assign o_rx_k = k;

    always @(posedge i_clk_sys)
    begin
        ph <= !ph;
        rv <= go;
        // Idle word toggles so no stale value looks valid
        if (!go)
        begin
            dw <= ~dw;
            k <= 4'h0;
        end
        else if (i_mode == 2'h2 && i_tx.dword == `HPW_ALIGN_DW)
        begin
            dw <= 32'h9595b57c;
            k <= 4'h1;
        end
        else
        begin
            dw <= `HPW_ALIGN_DW;
            k <= `HPW_ALIGN_K;
        end
    end
endmodule // hpw_dev_model

`default_nettype wire

// ==== sim/tb_host_phy_wake_align_ready.sv ====
/*
 Self-checking bench for hpw_top with the drive-side model.
 Assumes rtl on the include path; state is read through APB.
*/
`timescale 1ns/10ps
`default_nettype none

`include "hpw_regs.svh"

module tb_host_phy_wake_align_ready
    import hpw_pkg::*;
;
    localparam int TMO = 40;
    logic clk = 1'b0;
    logic srst = 1'b1, por = 1'b0, oob = 1'b1, cal = 1'b1, spd = 1'b0, rec = 1'b0;
    logic ini = 1'b0, wak = 1'b0, lp = 1'b0, ls = 1'b0, slow = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [31:0] ldw = 32'h0;
    logic [3:0] lk = 4'h0;
    logic idet, wdet, rv, wff;
    logic [31:0] rdw;
    logic [3:0] rk;
    hpw_apb_req_t apb = '0;
    hpw_apb_rsp_t rsp;
    hpw_tx_t tx;
    hpw_ctl_t ctl;
    logic [32:0] expq[$];
    int n_fail = 0, total_checks = 0, tick = 0;
    integer seed = 32'h3218;

    always #25 clk = ~clk;

    hpw_top #(.TMO_CYC(TMO)) uut (
        .i_clk_sys(clk), .i_srst(srst), .i_por(por), .i_init_det(idet),
        .i_wake_det(wdet), .i_oob_done(oob), .i_cal_done(cal), .i_speed_done(spd),
        .i_slumber_recovered(rec), .i_rx_valid(rv), .i_rx_dword(rdw), .i_rx_k(rk),
        .i_link_partial(lp), .i_link_slumber(ls), .i_link_dword(ldw), .i_link_k(lk),
        .i_apb(apb), .o_apb(rsp), .o_tx(tx), .o_ctl(ctl), .o_wake_from_far(wff)
    );
    hpw_dev_model dev (
        .i_clk_sys(clk), .i_tx(tx), .i_init(ini), .i_wake(wak), .i_mode(mode),
        .i_slow(slow), .o_init_det(idet), .o_wake_det(wdet), .o_rx_valid(rv),
        .o_rx_dword(rdw), .o_rx_k(rk)
    );

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [32:0] s, input logic [32:0] e);
        total_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Request held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        apb <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb.penable <= 1'b1;
        // Ends when pready is seen high, or at the bench ceiling
        do
        begin
            @(posedge clk);
        end
        while (rsp.pready !== 1'b1);
        apb <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic st(input hpw_state_t s);
        rd(`HPW_ADDR_STAT, {20'h0, s});
    endtask
    task automatic up();
        ini <= 1'b1;
        oob <= 1'b0;
        cyc(6);
        ini <= 1'b0;
        cyc(10);
        st(HPW_SEND_WAKE);
        chk({32'h0, ctl.send_wake}, 33'h1);
        oob <= 1'b1;
        cyc(2);
        st(HPW_WAIT_WAKE);
        wak <= 1'b1;
        cyc(6);
        st(HPW_WAKE_REL);
        wak <= 1'b0;
        cyc(8);
    endtask
    task automatic to_ready();
        mode <= 2'h1;
        spd <= 1'b0;
        slow <= 1'b0;
        up();
        cyc(4);
        st(HPW_SPEED_ADJ);
        spd <= 1'b1;
        cyc(4);
        st(HPW_SEND_ALIGN);
        chk({tx.dword == `HPW_ALIGN_DW, 27'h0, tx.quiet, tx.k}, {1'b1, 28'h0, `HPW_ALIGN_K});
        mode <= 2'h2;
        cyc(2);
        mode <= 2'h1;
        cyc(1);
        mode <= 2'h0;
        cyc(TMO + 20);
        st(HPW_SEND_ALIGN);
        mode <= 2'h2;
        slow <= 1'b1;
        cyc(12);
        st(HPW_READY);
        chk({32'h0, ctl.phy_rdy}, 33'h1);
    endtask

    always @(posedge clk)
    begin
        ldw <= $random(seed);
        lk <= 4'($random(seed));
        if (rsp.pready === 1'b1 && apb.pwrite === 1'b0 && expq.size() > 0)
            chk({rsp.pslverr, rsp.prdata}, expq.pop_front());
    end

    // Ceiling well above the several hundred cycles the run needs
    always @(posedge clk)
    begin
        tick++;
        if (tick == 4000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial
    begin
        cyc(6);
        srst <= 1'b0;
        rd(`HPW_ADDR_CTRL, 33'h0);
        st(HPW_AWAIT_INIT);
        rd(12'h010, {1'b1, 32'h0});
        up();
        chk({31'h0, ctl.rate_low, tx.dword == `HPW_D102_DW}, 33'h3);
        cyc(TMO + 20);
        st(HPW_AWAIT_INIT);
        xfer(1'b1, `HPW_ADDR_CTRL, 32'h1);
        rd(`HPW_ADDR_CTRL, 33'h1);
        up();
        cyc(TMO + 20);
        st(HPW_WAIT_ALIGN);
        rd(`HPW_ADDR_WAKE, 33'h2);
        xfer(1'b1, `HPW_ADDR_CTRL, 32'h0);
        to_ready();
        lp <= 1'b1;
        cyc(5);
        st(HPW_PARTIAL);
        wak <= 1'b1;
        cyc(4);
        lp <= 1'b0;
        cyc(4);
        st(HPW_WAKE_REL);
        chk({32'h0, wff}, 33'h1);
        wak <= 1'b0;
        cyc(30);
        st(HPW_READY);
        ls <= 1'b1;
        cyc(5);
        st(HPW_SLUMBER);
        chk({32'h0, ctl.pwr_slumber}, 33'h1);
        ls <= 1'b0;
        cyc(6);
        st(HPW_SLUMBER);
        rec <= 1'b1;
        cyc(8);
        st(HPW_WAIT_WAKE);
        chk({32'h0, wff}, 33'h0);
        ini <= 1'b1;
        cyc(4);
        st(HPW_INIT_REL);
        por <= 1'b1;
        cyc(6);
        st(HPW_RESET);
        tally_and_finish();
    end
endmodule // tb_host_phy_wake_align_ready

`default_nettype wire
